// File: cs_scan_pkg.sv
// Package for the capacitive-sense scan, threshold and mux control block.
// Assumes a byte-wide register port on the same clock as the block.
package cs_scan_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CS_OFS_THR_LOW   = 8'h96;
  localparam logic [7:0] CS_OFS_THR_HIGH  = 8'h97;
  localparam logic [7:0] CS_OFS_CHAN_SEL  = 8'h9c;
  localparam logic [7:0] CS_OFS_CONFIG    = 8'h9e;
  localparam logic [7:0] CS_OFS_FIRST     = 8'hb9;
  localparam logic [7:0] CS_OFS_LAST      = 8'hba;
  localparam logic [7:0] CS_OFS_CONTROL   = 8'hb0;
  localparam logic [7:0] CS_OFS_IRQ_STAT  = 8'hb1;
  localparam logic [7:0] CS_OFS_IRQ_MASK  = 8'hb2;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CS_BIT_DISCONNECT = 7;  // In channel select
  localparam int CS_BIT_BUSY       = 4;  // In control
  localparam int CS_BIT_CMP_EN     = 3;  // In control
  localparam int CS_BIT_CMP_FLAG   = 0;  // In control
  localparam int CS_POS_MODE       = 4;  // Mode field 6:4 in config
  localparam int CS_BIT_IRQ_DONE   = 0;  // In irq status and mask
  localparam int CS_BIT_IRQ_CMP    = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] CS_RST_CHAN       = 4'hf;
  localparam logic       CS_RST_DISCONNECT = 1'b1;
  localparam logic [4:0] CS_RST_SCAN       = 5'h00;
  localparam logic [7:0] CS_RST_THR        = 8'h00;

  // Start-of-conversion modes
  localparam logic [2:0] CS_MODE_ONESHOT = 3'b000;
  localparam logic [2:0] CS_MODE_TMR0    = 3'b001;
  localparam logic [2:0] CS_MODE_TMR2    = 3'b010;
  localparam logic [2:0] CS_MODE_TMR1    = 3'b011;
  localparam logic [2:0] CS_MODE_CONT    = 3'b110;
  localparam logic [2:0] CS_MODE_SCAN    = 3'b111;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cs_bus_req_t;

  // Converter result handed back with its done pulse
  typedef struct packed {
    logic        done;
    logic [15:0] result;
  } cs_conv_t;

endpackage

// File: cs_pin_mux.sv
// Channel-to-pin routing for the sense converter input.
// Assumes the select and disconnect come from flops on the same clock.
`timescale 1ns/1ns
module cs_pin_mux
  import cs_scan_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input  wire logic                ref_clk,     // System clock
  input  wire logic                rst,         // Sync reset, high
  input  wire logic [3:0]          chan,        // Selected channel
  input  wire logic                disconnect,  // Isolate from all pins
  output logic      [CHANNELS-1:0] pin_connect  // One-hot pin switch enables
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (CHANNELS < 1 || CHANNELS > 16) begin : g_chk
    $error("cs_pin_mux: CHANNELS must be 1 to 16");
  end

  logic [CHANNELS-1:0] next_pin_connect;

  // One switch closed at most; codes beyond CHANNELS close none
  always_comb begin
    next_pin_connect = '0;
    if (!disconnect && (32'(chan) < CHANNELS)) begin
      next_pin_connect[chan] = 1'b1;
    end
  end

  // Registered so the switches never glitch between channels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_connect <= '0;
    end else begin
      pin_connect <= next_pin_connect;
    end
  end

endmodule

// File: cs_scan_ctrl.sv
// Scan, threshold and input-mux control for the capacitive-sense converter.
// Assumes the converter core, timers and register master share ref_clk.
`timescale 1ns/1ns
module cs_scan_ctrl
  import cs_scan_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input  wire logic        ref_clk,      // 20 MHz system clock
  input  wire logic        rst,          // Sync reset, high
  input  wire cs_bus_req_t bus,          // Register request
  output logic      [7:0]  rdata,        // Read data, cycle after rd
  input  wire cs_conv_t    conv,         // Converter done and result
  input  wire logic [2:0]  timer_tick,   // Timer 0,2,1 overflow pulses
  output logic             conv_start,   // Start one conversion, pulse
  output logic      [CHANNELS-1:0] pin_connect, // Pin switch enables
  output logic             irq           // Level interrupt
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (CHANNELS < 1 || CHANNELS > 16) begin : g_chk
    $error("cs_scan_ctrl: CHANNELS must be 1 to 16");
  end

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] thr_low,    next_thr_low;
  logic [7:0] thr_high,   next_thr_high;
  logic [3:0] chan,       next_chan;
  logic       disconnect, next_disconnect;
  logic [4:0] first_ch,   next_first_ch;
  logic [4:0] last_ch,    next_last_ch;
  logic [2:0] mode,       next_mode;
  logic       busy,       next_busy;
  logic       cmp_en,     next_cmp_en;
  logic       cmp_flag,   next_cmp_flag;
  logic [1:0] irq_stat,   next_irq_stat;
  logic [1:0] irq_mask,   next_irq_mask;
  logic       next_conv_start;
  logic [7:0] next_rdata;

  logic        auto_scan;
  logic        go_write;
  logic        trig;
  logic [15:0] threshold;
  logic        above;

  // Step one channel or wrap to the first
  function automatic logic [3:0] scan_next(input logic [3:0] cur,
                                           input logic [4:0] lo,
                                           input logic [4:0] hi);
    scan_next = (cur == hi[3:0]) ? lo[3:0] : 4'(cur + 4'h1);
  endfunction

  // Register write hit
  function automatic logic wr_hit(input cs_bus_req_t b, input logic [7:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  // ************************************************************
  // Decode and compare
  // ************************************************************
  assign auto_scan = (mode == CS_MODE_SCAN);
  assign threshold = {thr_high, thr_low};
  assign above     = conv.result > threshold;
  // Busy write only starts in the firmware-started modes
  assign go_write  = wr_hit(bus, CS_OFS_CONTROL) && bus.wdata[CS_BIT_BUSY]
                     && (mode == CS_MODE_ONESHOT || mode == CS_MODE_CONT
                         || auto_scan);
  always_comb begin
    case (mode)
      CS_MODE_TMR0: trig = timer_tick[0];
      CS_MODE_TMR2: trig = timer_tick[1];
      CS_MODE_TMR1: trig = timer_tick[2];
      default:      trig = 1'b0;
    endcase
  end

  // ************************************************************
  // Register and scan next state
  // ************************************************************
  always_comb begin
    next_thr_low    = thr_low;
    next_thr_high   = thr_high;
    next_chan       = chan;
    next_disconnect = disconnect;
    next_first_ch   = first_ch;
    next_last_ch    = last_ch;
    next_mode       = mode;
    next_busy       = busy;
    next_cmp_en     = cmp_en;
    next_cmp_flag   = cmp_flag;
    next_irq_stat   = irq_stat;
    next_irq_mask   = irq_mask;
    next_conv_start = 1'b0;

    // Scan advance first, so firmware writes below take priority
    if (conv.done && busy && auto_scan) begin
      next_chan = scan_next(chan, first_ch, last_ch);
    end
    if (wr_hit(bus, CS_OFS_THR_LOW))  next_thr_low  = bus.wdata;
    if (wr_hit(bus, CS_OFS_THR_HIGH)) next_thr_high = bus.wdata;
    if (wr_hit(bus, CS_OFS_CHAN_SEL)) begin
      next_chan       = bus.wdata[3:0];
      next_disconnect = bus.wdata[CS_BIT_DISCONNECT];
    end
    if (wr_hit(bus, CS_OFS_FIRST)) begin
      next_first_ch = bus.wdata[4:0];
      if (auto_scan) next_chan = bus.wdata[3:0];
    end
    if (wr_hit(bus, CS_OFS_LAST)) next_last_ch = bus.wdata[4:0];
    if (wr_hit(bus, CS_OFS_CONFIG)) begin
      next_mode = bus.wdata[CS_POS_MODE +: 3];
    end
    if (wr_hit(bus, CS_OFS_IRQ_MASK)) next_irq_mask = bus.wdata[1:0];

    // Conversion sequencing; continuous modes restart on every done
    if (conv.done && busy) begin
      if (mode == CS_MODE_CONT || auto_scan) begin
        next_conv_start = 1'b1;
      end else begin
        next_busy = 1'b0;
      end
    end
    if (go_write && !busy) begin
      next_busy       = 1'b1;
      next_conv_start = 1'b1;
    end
    if (trig && !busy) begin
      next_busy       = 1'b1;
      next_conv_start = 1'b1;
    end

    // Flags: writing 0 clears cmp_flag, writing 1 clears an irq_stat bit; a same-cycle event wins
    if (wr_hit(bus, CS_OFS_CONTROL)) begin
      next_cmp_en = bus.wdata[CS_BIT_CMP_EN];
      if (!bus.wdata[CS_BIT_CMP_FLAG]) next_cmp_flag = 1'b0;
    end
    if (wr_hit(bus, CS_OFS_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~bus.wdata[1:0];
    end
    if (conv.done) begin
      next_irq_stat[CS_BIT_IRQ_DONE] = 1'b1;
      if (cmp_en && above) begin
        next_cmp_flag                 = 1'b1;
        next_irq_stat[CS_BIT_IRQ_CMP] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thr_low    <= CS_RST_THR;
      thr_high   <= CS_RST_THR;
      chan       <= CS_RST_CHAN;
      disconnect <= CS_RST_DISCONNECT;
      first_ch   <= CS_RST_SCAN;
      last_ch    <= CS_RST_SCAN;
      mode       <= CS_MODE_ONESHOT;
      busy       <= 1'b0;
      cmp_en     <= 1'b0;
      cmp_flag   <= 1'b0;
      irq_stat   <= 2'b00;
      irq_mask   <= 2'b00;
      conv_start <= 1'b0;
    end else begin
      thr_low    <= next_thr_low;
      thr_high   <= next_thr_high;
      chan       <= next_chan;
      disconnect <= next_disconnect;
      first_ch   <= next_first_ch;
      last_ch    <= next_last_ch;
      mode       <= next_mode;
      busy       <= next_busy;
      cmp_en     <= next_cmp_en;
      cmp_flag   <= next_cmp_flag;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      conv_start <= next_conv_start;
    end
  end

  // Level interrupt from masked sticky status
  assign irq = |(irq_stat & irq_mask);

  // ************************************************************
  // Read port
  // ************************************************************
  // Unused and unmapped bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        CS_OFS_THR_LOW:  next_rdata = thr_low;
        CS_OFS_THR_HIGH: next_rdata = thr_high;
        CS_OFS_CHAN_SEL: next_rdata = {disconnect, 3'b000, chan};
        CS_OFS_FIRST:    next_rdata = {3'b000, first_ch};
        CS_OFS_LAST:     next_rdata = {3'b000, last_ch};
        CS_OFS_CONFIG:   next_rdata = {1'b0, mode, 4'h0};
        CS_OFS_CONTROL:  next_rdata = {3'b000, busy, cmp_en, 2'b00, cmp_flag};
        CS_OFS_IRQ_STAT: next_rdata = {6'h00, irq_stat};
        CS_OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // Held only in the cycle after the read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Pin routing
  // ************************************************************
  cs_pin_mux #(
    .CHANNELS    (CHANNELS)
  ) u_pin_mux (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .chan        (chan),
    .disconnect  (disconnect),
    .pin_connect (pin_connect)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_scan_go;
    auto_scan && go_write && !busy;
  endsequence
  sequence s_running;
    busy && conv_start;
  endsequence

  a_first_load: assert property (
    wr_hit(bus, CS_OFS_FIRST) && auto_scan && !wr_hit(bus, CS_OFS_CHAN_SEL)
    |=> chan == $past(bus.wdata[3:0]))
    else $error("first-channel write did not load channel select");

  a_scan_wrap: assert property (
    conv.done && busy && auto_scan && chan == last_ch[3:0]
    && !wr_hit(bus, CS_OFS_CHAN_SEL) && !wr_hit(bus, CS_OFS_FIRST)
    |=> chan == first_ch[3:0])
    else $error("scan did not wrap to first channel");

  a_scan_step: assert property (
    conv.done && busy && auto_scan && chan != last_ch[3:0]
    && !wr_hit(bus, CS_OFS_CHAN_SEL) && !wr_hit(bus, CS_OFS_FIRST)
    |=> chan == 4'($past(chan) + 4'h1))
    else $error("scan did not step channel");

  a_unused_zero: assert property (
    bus.rd && (bus.addr == CS_OFS_FIRST || bus.addr == CS_OFS_LAST)
    |=> rdata[7:5] == 3'b000)
    else $error("scan channel upper bits not zero");

  a_cmp_flag: assert property (
    conv.done && cmp_en && conv.result > {thr_high, thr_low}
    |=> cmp_flag && irq_stat[CS_BIT_IRQ_CMP])
    else $error("compare flag not set above threshold");

  a_disc_iso: assert property (
    disconnect |=> pin_connect == '0)
    else $error("pins connected while disconnected");

  a_conn_route: assert property (
    !disconnect && 32'(chan) < CHANNELS
    |=> pin_connect == (CHANNELS'(1) << $past(chan)))
    else $error("wrong pin connected");

  a_mux_write: assert property (
    wr_hit(bus, CS_OFS_CHAN_SEL)
    |=> chan == $past(bus.wdata[3:0]) && disconnect == $past(bus.wdata[7]))
    else $error("channel select write lost");

  a_scan_run: assert property (
    s_scan_go |=> s_running ##1 busy)
    else $error("auto-scan did not start");

endmodule

// File: cs_conv_model.sv
// Behavioural stand-in for the sense converter core on the far side of the block.
// Assumes conv_start is a one-cycle pulse on ref_clk; answers after one or five cycles.
`timescale 1ns/1ns
module cs_conv_model
  import cs_scan_pkg::*;
(
  input  wire logic        ref_clk,     // System clock
  input  wire logic        rst,         // Sync reset, high
  input  wire logic        conv_start,  // Start pulse from the block
  input  wire logic        slow,        // Five-cycle conversion when set
  input  wire logic [15:0] res_in,      // Result handed back with done
  output cs_conv_t         conv         // Done pulse and result
);
  // ************************************************************
  // Conversion timer
  // ************************************************************
  int cnt = 0;

  initial conv = '0;

  // Result bus toggles outside done, so a stale value never looks valid
  always @(posedge ref_clk) begin
    if (!rst && !conv_start && cnt == 1) begin
      conv <= '{done: 1'b1, result: res_in};
    end else begin
      conv <= '{done: 1'b0, result: ~conv.result};
    end
    if (rst) begin
      cnt <= 0;
    end else if (conv_start) begin
      cnt <= slow ? 5 : 1;
    end else if (cnt == 1) begin
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the scan, threshold and mux control block.
// Assumes the converter model answers every start; expectations are worked out here.
`timescale 1ns/1ns
module testbench;
  import cs_scan_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic        ref_clk    = 1'b0;
  logic        rst        = 1'b1;
  cs_bus_req_t bus        = '0;
  logic [7:0]  rdata;
  cs_conv_t    conv;
  logic [2:0]  timer_tick = 3'b000;
  logic        conv_start;
  logic [15:0] pin_connect;
  logic        irq;
  logic        slow       = 1'b0;
  logic [15:0] res_in     = 16'h0000;
  logic [15:0] thr;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          seed       = 32'ha6fea773;
  int          exp_ch[$];

  always #25 ref_clk = ~ref_clk;

  cs_scan_ctrl #(.CHANNELS(16)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .conv(conv),
    .timer_tick(timer_tick), .conv_start(conv_start), .pin_connect(pin_connect), .irq(irq)
  );

  cs_conv_model conv_u (
    .ref_clk(ref_clk), .rst(rst), .conv_start(conv_start), .slow(slow),
    .res_in(res_in), .conv(conv)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task end_sim;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; a gap cycle follows each call
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  // Looks first, then waits: the pulse may already stand after the strobe edge
  task wait_start;
    int i;
    for (i = 0; i < 60; i++) begin
      #1;
      if (conv_start === 1'b1) break;
      @(posedge ref_clk);
    end
    if (i == 60) begin
      mismatches++;
      end_sim();
    end
  endtask

  task conv_once(input logic [15:0] res, input logic s);
    res_in <= res;
    slow   <= s;
    wr(CS_OFS_CONTROL, 8'h18);
    wait_start();
    repeat (8) @(posedge ref_clk);
  endtask

  // Hang guard, well past the whole sequence
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("thr_low", CS_OFS_THR_LOW, 8'h00);
    rdchk("thr_high", CS_OFS_THR_HIGH, 8'h00);
    rdchk("chan_sel", CS_OFS_CHAN_SEL, 8'h8f);
    rdchk("first", CS_OFS_FIRST, 8'h00);
    rdchk("last", CS_OFS_LAST, 8'h00);
    rdchk("unmapped", 8'h55, 8'h00);
    chk("pin_idle", 16'h0000, pin_connect);
    wr(CS_OFS_FIRST, 8'hff);
    rdchk("first", CS_OFS_FIRST, 8'h1f);
    wr(CS_OFS_LAST, 8'he3);
    rdchk("last", CS_OFS_LAST, 8'h03);
    // Every channel code, then the same code with the pins isolated
    for (int c = 0; c < 16; c++) begin
      wr(CS_OFS_CHAN_SEL, 8'h70 | 8'(c));
      @(posedge ref_clk);
      #1 chk("pin_connect", 16'h0001 << c, pin_connect);
      wr(CS_OFS_CHAN_SEL, 8'h80 | 8'(c));
      @(posedge ref_clk);
      #1 chk("pin_off", 16'h0000, pin_connect);
    end
    rdchk("chan_sel", CS_OFS_CHAN_SEL, 8'h8f);
    // Threshold just below and equal to the result
    thr = 16'($random(seed)) & 16'h7fff;
    wr(CS_OFS_THR_LOW, thr[7:0]);
    wr(CS_OFS_THR_HIGH, thr[15:8]);
    rdchk("thr_low", CS_OFS_THR_LOW, thr[7:0]);
    rdchk("thr_high", CS_OFS_THR_HIGH, thr[15:8]);
    wr(CS_OFS_IRQ_MASK, 8'h00);
    conv_once(thr + 16'h0001, 1'b1);
    #1 chk("irq_masked", 16'h0000, {15'h0000, irq});
    rdchk("irq_stat", CS_OFS_IRQ_STAT, 8'h03);
    rdchk("control", CS_OFS_CONTROL, 8'h09);
    wr(CS_OFS_IRQ_MASK, 8'h02);
    #1 chk("irq_on", 16'h0001, {15'h0000, irq});
    wr(CS_OFS_IRQ_STAT, 8'h02);
    #1 chk("irq_clr", 16'h0000, {15'h0000, irq});
    wr(CS_OFS_CONTROL, 8'h08);
    conv_once(thr, 1'b0);
    rdchk("irq_stat", CS_OFS_IRQ_STAT, 8'h01);
    rdchk("control", CS_OFS_CONTROL, 8'h08);
    wr(CS_OFS_IRQ_MASK, 8'h01);
    #1 chk("irq_done", 16'h0001, {15'h0000, irq});
    wr(CS_OFS_IRQ_STAT, 8'hff);
    #1 chk("irq_clr", 16'h0000, {15'h0000, irq});
    // Timer-started modes, one tick line each
    for (int m = 1; m < 4; m++) begin
      wr(CS_OFS_CONFIG, 8'(m << 4));
      @(posedge ref_clk);
      timer_tick <= 3'(1 << (m - 1));
      @(posedge ref_clk);
      timer_tick <= 3'b000;
      wait_start();
      repeat (8) @(posedge ref_clk);
    end
    // Auto-scan from 2 to 4 with wrap, mixing fast and slow answers
    wr(CS_OFS_CHAN_SEL, 8'h00);
    wr(CS_OFS_CONFIG, 8'h70);
    wr(CS_OFS_LAST, 8'h04);
    wr(CS_OFS_FIRST, 8'h02);
    @(posedge ref_clk);
    #1 chk("first_load", 16'h0004, pin_connect);
    for (int k = 0; k < 5; k++) exp_ch.push_back(2 + k % 3);
    wr(CS_OFS_CONTROL, 8'h10);
    foreach (exp_ch[k]) begin
      slow <= k[0];
      wait_start();
      @(posedge ref_clk);
      #1 chk("scan_chan", 16'h0001 << exp_ch[k], pin_connect);
    end
    wr(CS_OFS_CONFIG, 8'h00);
    repeat (20) @(posedge ref_clk);
    end_sim();
  end
endmodule
